// ==== duhp_defines.vh ====
// constants for the dual uart host bus port
`ifndef DUHP_DEFINES_VH
`define DUHP_DEFINES_VH
`define DUHP_REG_COUNT 8
`define DUHP_ADDR_W 3
`define DUHP_DATA_W 8
`define DUHP_OFS_IRQ_EN 3'h1
`define DUHP_OFS_MODEM_CTL 3'h4
`define DUHP_OFS_SCRATCH 3'h7
`define DUHP_MCR_IRQ_GATE_BIT 3
`define DUHP_IER_RX_AVAIL_BIT 0
`define DUHP_IER_TX_EMPTY_BIT 1
`define DUHP_IER_RX_ERR_BIT 2
`define DUHP_IER_MODEM_BIT 3
`define DUHP_RESET_VAL 8'h00
`endif

// ==== duhp_regbank.v ====
// register storage for one channel: eight bytes, registered read data
`include "duhp_defines.vh"
module duhp_regbank (
    input wire mclk, // system clock
    input wire arst_n, // async reset, active low
    input wire wr_en, // one-cycle write pulse
    input wire [2:0] addr, // register index
    input wire [7:0] wdata, // byte to store
    output reg [7:0] rdata, // registered read byte
    output wire [7:0] irq_en, // interrupt enable contents
    output wire [7:0] modem_ctl // modem control contents
);
    reg [7:0] mem_r [0:7];
    integer i;
    // storage, read data follows address each cycle
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                mem_r[i] <= `DUHP_RESET_VAL;
            end
            rdata <= `DUHP_RESET_VAL;
        end else begin
            if (wr_en) begin
                mem_r[addr] <= wdata;
            end
            rdata <= mem_r[addr];
        end
    end
    assign irq_en = mem_r[`DUHP_OFS_IRQ_EN];
    assign modem_ctl = mem_r[`DUHP_OFS_MODEM_CTL];
endmodule

// ==== duhp_port.v ====
// two-channel parallel host port: selects, strobes, data bus, irq and user outputs
`include "duhp_defines.vh"
module duhp_port (
    input wire mclk, // 100 MHz system clock
    input wire arst_n, // async reset, active low
    input wire chan_a_select_n, // channel a select
    input wire chan_b_select_n, // channel b select
    input wire read_strobe_n, // read strobe
    input wire write_strobe_n, // write strobe
    input wire reg_sel_bit0, // register address bit 0
    input wire reg_sel_bit1, // register address bit 1
    input wire reg_sel_bit2, // register address bit 2
    input wire [7:0] bus_in, // data bus as seen on the pins
    output reg [7:0] bus_out, // data bus drive value
    output reg bus_oe_n, // data bus enable, low drives
    input wire [3:0] chan_a_events, // a: rx err, rx data, tx empty, modem
    input wire [3:0] chan_b_events, // b: rx err, rx data, tx empty, modem
    output reg chan_a_irq, // channel a interrupt level
    output reg chan_a_irq_oe_n, // channel a interrupt enable, low drives
    output reg chan_b_irq, // channel b interrupt level
    output reg chan_b_irq_oe_n, // channel b interrupt enable, low drives
    output reg chan_a_user_out, // channel a user output
    output reg chan_b_user_out // channel b user output
);
    // synchroniser stages for the select pins
    reg sel_a_s1_r;
    reg sel_a_s2_r;
    reg sel_b_s1_r;
    reg sel_b_s2_r;
    // synchroniser stages for the strobes
    reg rd_s1_r;
    reg rd_s2_r;
    reg wr_s1_r;
    reg wr_s2_r;
    // synchroniser stages for the address bits
    reg [2:0] addr_s1_r;
    reg [2:0] addr_s2_r;
    // synchroniser stages for the data bus and the events
    reg [7:0] bus_s1_r;
    reg [7:0] bus_s2_r;
    reg [7:0] ev_s1_r;
    reg [7:0] ev_s2_r;
    // strobe history for edge detection
    reg rd_prev_r;
    reg wr_prev_r;
    // selects rest high so no channel is picked out of reset
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_a_s1_r <= 1'b1;
            sel_a_s2_r <= 1'b1;
            sel_b_s1_r <= 1'b1;
            sel_b_s2_r <= 1'b1;
        end else begin
            sel_a_s1_r <= chan_a_select_n;
            sel_a_s2_r <= sel_a_s1_r;
            sel_b_s1_r <= chan_b_select_n;
            sel_b_s2_r <= sel_b_s1_r;
        end
    end
    // strobes rest high, as the idle pins do, so no false edge follows reset
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_s1_r <= 1'b1;
            rd_s2_r <= 1'b1;
            wr_s1_r <= 1'b1;
            wr_s2_r <= 1'b1;
        end else begin
            rd_s1_r <= read_strobe_n;
            rd_s2_r <= rd_s1_r;
            wr_s1_r <= write_strobe_n;
            wr_s2_r <= wr_s1_r;
        end
    end
    // address bits settle while the strobes are still high
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            addr_s1_r <= 3'h7;
            addr_s2_r <= 3'h7;
        end else begin
            addr_s1_r <= {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
            addr_s2_r <= addr_s1_r;
        end
    end
    // data bus and event levels, sampled like any other pin
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_s1_r <= 8'h00;
            bus_s2_r <= 8'h00;
            ev_s1_r <= 8'h00;
            ev_s2_r <= 8'h00;
        end else begin
            bus_s1_r <= bus_in;
            bus_s2_r <= bus_s1_r;
            ev_s1_r <= {chan_b_events, chan_a_events};
            ev_s2_r <= ev_s1_r;
        end
    end
    // strobe history reads only the second stage
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
        end else begin
            rd_prev_r <= rd_s2_r;
            wr_prev_r <= wr_s2_r;
        end
    end
    // settled views of the pins for the rest of the block
    wire [1:0] sel_n = {sel_b_s2_r, sel_a_s2_r};
    wire rd_n = rd_s2_r;
    wire wr_n = wr_s2_r;
    wire [2:0] addr = addr_s2_r;
    wire wr_fall = wr_prev_r & ~wr_n;
    wire rd_fall = rd_prev_r & ~rd_n;
    wire [7:0] rdata [0:1];
    wire [7:0] ien [0:1];
    wire [7:0] mctl [0:1];
    wire [1:0] irq_lvl;
    // one register bank per channel
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            // write to each selected channel; both banks take the write when both selects are low
            wire wr_this = wr_fall & ~sel_n[g];
            duhp_regbank u_bank (
                .mclk(mclk),
                .arst_n(arst_n),
                .wr_en(wr_this),
                .addr(addr),
                .wdata(bus_s2_r),
                .rdata(rdata[g]),
                .irq_en(ien[g]),
                .modem_ctl(mctl[g])
            );
            assign irq_lvl[g] = (ev_s2_r[4*g+0] & ien[g][`DUHP_IER_RX_ERR_BIT])
                | (ev_s2_r[4*g+1] & ien[g][`DUHP_IER_RX_AVAIL_BIT])
                | (ev_s2_r[4*g+2] & ien[g][`DUHP_IER_TX_EMPTY_BIT])
                | (ev_s2_r[4*g+3] & ien[g][`DUHP_IER_MODEM_BIT]);
        end
    endgenerate
    // read tracking: which channel's bank feeds the bus
    reg rd_active_r;
    reg rd_chan_r;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_active_r <= 1'b0;
            rd_chan_r <= 1'b0;
        end else if (rd_n || (&sel_n)) begin
            rd_active_r <= 1'b0;
        end else if (rd_fall) begin
            rd_active_r <= 1'b1;
            rd_chan_r <= sel_n[0];
        end
    end
    wire [1:0] gate = {mctl[1][`DUHP_MCR_IRQ_GATE_BIT], mctl[0][`DUHP_MCR_IRQ_GATE_BIT]};
    // data bus drive: read byte and enable
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_out <= 8'h00;
            bus_oe_n <= 1'b1;
        end else begin
            bus_out <= rdata[rd_chan_r];
            bus_oe_n <= ~(rd_active_r & ~rd_n & ~sel_n[rd_chan_r]);
        end
    end
    // channel a interrupt pin: level and drive enable
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chan_a_irq <= 1'b0;
            chan_a_irq_oe_n <= 1'b1;
        end else begin
            chan_a_irq <= gate[0] & irq_lvl[0];
            chan_a_irq_oe_n <= ~gate[0];
        end
    end
    // channel b interrupt pin: level and drive enable
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chan_b_irq <= 1'b0;
            chan_b_irq_oe_n <= 1'b1;
        end else begin
            chan_b_irq <= gate[1] & irq_lvl[1];
            chan_b_irq_oe_n <= ~gate[1];
        end
    end
    // user outputs show the inverse of the gate bit
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chan_a_user_out <= 1'b1;
            chan_b_user_out <= 1'b1;
        end else begin
            // low while the gate bit is set; high when clear
            chan_a_user_out <= ~gate[0];
            chan_b_user_out <= ~gate[1];
        end
    end
endmodule

// ==== duhp_monitor.sv ====
// checker for the host port outputs
module duhp_monitor (
    input wire mclk, // clock
    input wire arst_n, // reset
    input wire chan_a_select_n, // select a
    input wire chan_b_select_n, // select b
    input wire read_strobe_n, // read
    input wire write_strobe_n, // write
    input wire bus_oe_n, // bus enable
    input wire chan_a_irq, // irq a
    input wire chan_a_irq_oe_n, // irq a enable
    input wire chan_b_irq, // irq b
    input wire chan_b_irq_oe_n, // irq b enable
    input wire chan_a_user_out, // user a
    input wire chan_b_user_out // user b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_drv; $fell(bus_oe_n) |->
        $past(!read_strobe_n && !(chan_a_select_n && chan_b_select_n), 2); endproperty
    a_drv: assert property (p_drv) else $error("bus driven without read");
    property p_idle; read_strobe_n [*6] |-> bus_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("bus held after read");
    property p_ans; $fell(read_strobe_n) && !chan_a_select_n |-> ##[2:6] !bus_oe_n; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_mode_a; chan_a_user_out == chan_a_irq_oe_n; endproperty
    a_mode_a: assert property (p_mode_a) else $error("mode a mismatch");
    property p_mode_b; chan_b_user_out == chan_b_irq_oe_n; endproperty
    a_mode_b: assert property (p_mode_b) else $error("mode b mismatch");
    property p_irq; chan_a_irq |-> !chan_a_irq_oe_n; endproperty
    a_irq: assert property (p_irq) else $error("irq raised while floating");
    property p_irq_b; chan_b_irq |-> !chan_b_irq_oe_n; endproperty
    a_irq_b: assert property (p_irq_b) else $error("irq b raised while floating");
    property p_rst; $rose(arst_n) |-> bus_oe_n && chan_a_user_out && chan_b_user_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset state");
    property p_usr; $changed(chan_a_user_out) |-> $past(!write_strobe_n && !chan_a_select_n, 3);
    endproperty
    a_usr: assert property (p_usr) else $error("user out moved without write");
    c_read: cover property ($fell(bus_oe_n));
    c_irq: cover property (chan_a_irq);
    c_user: cover property ($fell(chan_a_user_out));
    c_irq_b: cover property (chan_b_irq);
endmodule
bind duhp_port duhp_monitor i_duhp_monitor (.mclk(mclk), .arst_n(arst_n),
    .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .bus_oe_n(bus_oe_n),
    .chan_a_irq(chan_a_irq), .chan_a_irq_oe_n(chan_a_irq_oe_n), .chan_b_irq(chan_b_irq),
    .chan_b_irq_oe_n(chan_b_irq_oe_n), .chan_a_user_out(chan_a_user_out),
    .chan_b_user_out(chan_b_user_out));

// ==== duhp_host_model.sv ====
// host cpu model on the parallel bus
module duhp_host_model (
    input wire mclk, // clock
    input wire [7:0] bus_out, // device drive value
    input wire bus_oe_n, // device drive enable
    output logic [7:0] bus_in, // resolved bus
    output logic [1:0] sel_n, // selects a and b
    output logic rd_n, // read strobe
    output logic wr_n, // write strobe
    output logic [2:0] addr // register index
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hd = 8'h00;
    logic hoe = 1'b0;
    logic [7:0] last_r = 8'h00;
    initial {sel_n, rd_n, wr_n, addr} = 7'h7f;
    // floating bus toggles every cycle
    assign bus_in = !bus_oe_n ? bus_out : hoe ? hd : ~last_r;
    always @(posedge mclk) last_r <= bus_in;
    task automatic xfer(input logic [1:0] s, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        sel_n <= s;
        addr <= a;
        hd <= d;
        hoe <= wr;
        @(posedge mclk);
        rd_n <= wr;
        wr_n <= !wr;
        repeat (8) @(posedge mclk);
        q = bus_in;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (5) @(posedge mclk);
        sel_n <= 2'b11;
        hoe <= 1'b0;
    endtask
endmodule

// ==== tb_top.sv ====
// testbench for the host port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] ev_a = 4'h0, ev_b = 4'h0;
    wire [7:0] bin, bout;
    wire [1:0] sel_n;
    wire [2:0] addr;
    wire rd_n, wr_n, oe_n, irq_a, ioe_a, irq_b, ioe_b, usr_a, usr_b;
    int failures = 0, compares = 0, cyc = 0;
    always #5 mclk = ~mclk;
    duhp_port i_duhp_port (.mclk(mclk), .arst_n(arst_n), .chan_a_select_n(sel_n[1]),
        .chan_b_select_n(sel_n[0]), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .reg_sel_bit0(addr[0]), .reg_sel_bit1(addr[1]), .reg_sel_bit2(addr[2]),
        .bus_in(bin), .bus_out(bout), .bus_oe_n(oe_n), .chan_a_events(ev_a),
        .chan_b_events(ev_b), .chan_a_irq(irq_a), .chan_a_irq_oe_n(ioe_a), .chan_b_irq(irq_b),
        .chan_b_irq_oe_n(ioe_b), .chan_a_user_out(usr_a), .chan_b_user_out(usr_b));
    duhp_host_model host (.mclk(mclk), .bus_out(bout), .bus_oe_n(oe_n), .bus_in(bin),
        .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic t_reset;
        chk("idle", 8'h1f, {irq_a, irq_b, oe_n, usr_a, usr_b, ioe_a, ioe_b});
        chk("idle_bus", 8'h00, bout);
        $display("test reset done");
    endtask
    task automatic t_rw;
        logic [7:0] q;
        host.xfer(2'b01, 1'b1, 3'h7, 8'h5a, q);
        host.xfer(2'b10, 1'b1, 3'h7, 8'h12, q);
        host.xfer(2'b11, 1'b1, 3'h7, 8'hff, q);
        host.xfer(2'b01, 1'b0, 3'h7, 8'h00, q);
        chk("scr_a", 8'h5a, q);
        host.xfer(2'b10, 1'b0, 3'h7, 8'h00, q);
        chk("scr_b", 8'h12, q);
        host.xfer(2'b01, 1'b0, 3'h6, 8'h00, q);
        chk("other", 8'h00, q);
        host.xfer(2'b00, 1'b1, 3'h5, 8'h3c, q);
        host.xfer(2'b10, 1'b0, 3'h5, 8'h00, q);
        chk("both_b", 8'h3c, q);
        $display("test rw done");
    endtask
    task automatic t_irq;
        logic [7:0] q;
        int m[4] = '{2, 0, 1, 3};
        ev_b <= 4'hf;
        host.xfer(2'b01, 1'b1, 3'h4, 8'h08, q);
        chk("on_a", 8'h00, {usr_a, ioe_a});
        for (int i = 0; i < 4; i++) begin
            host.xfer(2'b01, 1'b1, 3'h1, 8'h01 << m[i], q);
            ev_a <= 4'h1 << ((i + 1) % 4);
            repeat (6) @(posedge mclk);
            chk("irq_off", 8'h00, irq_a);
            ev_a <= 4'h1 << i;
            repeat (6) @(posedge mclk);
            chk("irq_on", 8'h01, irq_a);
        end
        host.xfer(2'b10, 1'b1, 3'h1, 8'h0f, q);
        host.xfer(2'b10, 1'b1, 3'h4, 8'h08, q);
        chk("on_b", 8'h04, {irq_b, ioe_b, usr_b});
        host.xfer(2'b01, 1'b1, 3'h4, 8'h00, q);
        host.xfer(2'b10, 1'b1, 3'h4, 8'h00, q);
        chk("irq_b_off", 8'h00, irq_b);
        chk("off_ab", 8'h0f, {usr_a, ioe_a, usr_b, ioe_b});
        $display("test irq done");
    endtask
    task automatic t_rerun;
        logic [7:0] q;
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        t_reset;
        arst_n <= 1'b1;
        host.xfer(2'b01, 1'b0, 3'h7, 8'h00, q);
        chk("cleared", 8'h00, q);
        $display("test rerun done");
    endtask
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            test_done;
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        t_reset;
        arst_n <= 1'b1;
        t_rw;
        t_irq;
        t_rerun;
        test_done;
    end
endmodule
